// *** casp_defs.vh ***
// Constants for the codec audio serial port
`ifndef CASP_DEFS_VH
`define CASP_DEFS_VH
// ----------------------------------------
// APB map (index, byte address = 4 x index)
// ----------------------------------------
`define CASP_IDX_CTRL0 4'h7
`define CASP_IDX_CLKCFG 4'h8
`define CASP_IDX_CAPL 4'h9
`define CASP_IDX_CAPR 4'ha
`define CASP_IDX_PLAYL 4'hb
`define CASP_IDX_PLAYR 4'hc
`define CASP_IDX_STAT 4'hd
// ----------------------------------------
// interface_control_zero fields
// ----------------------------------------
`define CASP_PMX_BIT 12
`define CASP_PSLOT_BIT 11
`define CASP_CMX_BIT 10
`define CASP_CSLOT_BIT 9
`define CASP_ROLE_BIT 6
`define CASP_POL_BIT 4
`define CASP_WL_MSB 3
`define CASP_WL_LSB 2
`define CASP_FMT_MSB 1
`define CASP_FMT_LSB 0
`define CASP_CTRL0_MASK 16'h1e5f
`define CASP_CTRL0_RST 16'h000a
// ----------------------------------------
// Clock configuration fields and resets
// ----------------------------------------
`define CASP_DIV_MSB 7
`define CASP_DIV_LSB 0
`define CASP_HALF_MSB 23
`define CASP_HALF_LSB 16
`define CASP_RUN_BIT 31
`define CASP_DIV_RST 8'h01
`define CASP_HALF_RST 8'h20
// ----------------------------------------
// Format and word length codes
// ----------------------------------------
`define CASP_FMT_RJ 2'h0
`define CASP_FMT_LJ 2'h1
`define CASP_FMT_I2S 2'h2
`define CASP_FMT_DSP 2'h3
`define CASP_WL_16 2'h0
`define CASP_WL_20 2'h1
`define CASP_WL_24 2'h2
`define CASP_LEN_16 6'h10
`define CASP_LEN_20 6'h14
`define CASP_LEN_24 6'h18
`define CASP_LEN_32 6'h20
// ----------------------------------------
// Framing positions and sample layout
// ----------------------------------------
`define CASP_FIRST_EDGE 9'h001
`define CASP_SECOND_EDGE 9'h002
`define CASP_MCNT_IDLE 9'h1ff
`define CASP_SAMPLE_MSB 5'h17
`define CASP_SAMPLE_LEN 6'h18
`endif

// *** casp_sync.v ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module casp_sync (
    input wire pclk,
    input wire presetn,
    input wire din,
    output reg dout
);
    reg s1_reg; // Metastability catcher, read only by s2
    reg s2_reg;
    reg s3_reg;

    // ----------------------------------------
    // Shift chain; output moves once stages 2 and 3 agree
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // Agreement filters a one-cycle glitch out of stage 2
            if (s2_reg == s3_reg) begin
                dout <= s3_reg;
            end
        end
    end
endmodule // casp_sync

// *** casp_serial_port.v ***
// Codec audio serial port: APB registers, clock master and serial framing
// Summary of operation
// - Four lines: capture out, playback in, two clocks
// - Master drives both clocks, slave receives them
// - Role bit 6 of 07h, 0 slave
// - Four framing formats, always MSB first
// - Two-slot multiplexing in all formats and roles
// - 32-bit words: low 8 bits ignored/undriven
// - Bit clock divided from system clock, repeatable
// - Right justified: LSB on last edge before transition
// - Left justified: MSB on first edge after transition
// - I2S: MSB on second edge after transition
// - DSP: variant picks first or second edge
// - DSP: right channel follows left without gap
// - Master DSP frame clock is one-bit pulse
// - DSP PCM mono travels as left channel
// - Format field codes, I2S after reset
// - Word length field codes, 24 after reset
// - Multiplexed capture line released outside own slot
// - Slot select bits, slot 0 after reset
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`include "casp_defs.vh"
module casp_serial_port (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire bclk_in,
    output wire bclk_out,
    output wire bclk_oe,
    input wire lrclk_in,
    output wire lrclk_out,
    output wire lrclk_oe,
    output reg capture_serial_out,
    output reg capture_oe,
    input wire playback_serial_in
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [15:0] ctrl0_reg; // interface_control_zero
    reg [7:0] div_reg; // Bit clock divider
    reg [7:0] half_reg; // Bit clocks per half frame (master)
    reg run_reg; // Port enable
    reg [23:0] cap_left_reg; // Capture samples from software
    reg [23:0] cap_right_reg;
    reg [23:0] play_left_reg; // Playback samples received
    reg [23:0] play_right_reg;
    reg [1:0] stat_reg; // Sticky received flags
    reg [1:0] stat_next;
    reg [1:0] stat_set;
    reg [31:0] rd_mux;
    reg rd_err;
    wire lrclk_sel; // Frame clock level reported in status

    // Field decode
    wire [1:0] fmt = ctrl0_reg[`CASP_FMT_MSB:`CASP_FMT_LSB];
    wire [1:0] wl = ctrl0_reg[`CASP_WL_MSB:`CASP_WL_LSB];
    wire role = ctrl0_reg[`CASP_ROLE_BIT];
    wire pol = ctrl0_reg[`CASP_POL_BIT];
    wire cmx = ctrl0_reg[`CASP_CMX_BIT];
    wire pmx = ctrl0_reg[`CASP_PMX_BIT];
    // Slot ignored when multiplexing is off
    wire cslot = cmx & ctrl0_reg[`CASP_CSLOT_BIT];
    wire pslot = pmx & ctrl0_reg[`CASP_PSLOT_BIT];
    wire is_dsp = (fmt == `CASP_FMT_DSP);

    // ----------------------------------------
    // APB slave: zero wait, registered read data
    // ----------------------------------------
    wire apb_setup = psel & ~penable;
    wire apb_wr = psel & penable & pwrite;
    wire addr_ok = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0);
    wire [3:0] aidx = paddr[5:2];
    assign pready = 1'b1;

    // Read multiplexer, reserved bits read zero
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        if (!addr_ok) begin
            rd_err = 1'b1;
        end else begin
            case (aidx)
                `CASP_IDX_CTRL0: rd_mux = {16'h0000, ctrl0_reg};
                `CASP_IDX_CLKCFG: rd_mux = {run_reg, 7'h00, half_reg, 8'h00, div_reg};
                `CASP_IDX_CAPL: rd_mux = {8'h00, cap_left_reg};
                `CASP_IDX_CAPR: rd_mux = {8'h00, cap_right_reg};
                `CASP_IDX_PLAYL: rd_mux = {8'h00, play_left_reg};
                `CASP_IDX_PLAYR: rd_mux = {8'h00, play_right_reg};
                `CASP_IDX_STAT: rd_mux = {28'h0000000, capture_oe, lrclk_sel, stat_reg};
                default: rd_err = 1'b1; // Unmapped word
            endcase
        end
    end

    // Capture the answer in setup so the access phase sees flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= rd_err;
        end
    end

    // Software writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_reg <= `CASP_CTRL0_RST;
            div_reg <= `CASP_DIV_RST;
            half_reg <= `CASP_HALF_RST;
            run_reg <= 1'b0;
            cap_left_reg <= 24'h000000;
            cap_right_reg <= 24'h000000;
        end else if (apb_wr && addr_ok) begin
            case (aidx)
                `CASP_IDX_CTRL0: ctrl0_reg <= pwdata[15:0] & `CASP_CTRL0_MASK;
                `CASP_IDX_CLKCFG: begin
                    div_reg <= pwdata[`CASP_DIV_MSB:`CASP_DIV_LSB];
                    half_reg <= pwdata[`CASP_HALF_MSB:`CASP_HALF_LSB];
                    run_reg <= pwdata[`CASP_RUN_BIT];
                end
                `CASP_IDX_CAPL: cap_left_reg <= pwdata[23:0];
                `CASP_IDX_CAPR: cap_right_reg <= pwdata[23:0];
                default: ; // Read-only or unmapped
            endcase
        end
    end

    // Word length decode
    reg [5:0] wl_len;
    always @* begin
        case (wl)
            `CASP_WL_16: wl_len = `CASP_LEN_16;
            `CASP_WL_20: wl_len = `CASP_LEN_20;
            `CASP_WL_24: wl_len = `CASP_LEN_24;
            default: wl_len = `CASP_LEN_32;
        endcase
    end

    // ----------------------------------------
    // Master clock generation
    // ----------------------------------------
    reg [7:0] div_cnt_reg;
    reg bclk_m_reg;
    reg [8:0] mcnt_reg; // Bit position within the frame
    reg lr_m_reg;
    reg m_lr_next;
    wire m_act = run_reg & role;
    wire tick = m_act & (div_cnt_reg == div_reg);
    wire m_fall = tick & bclk_m_reg;
    wire m_rise = tick & ~bclk_m_reg;
    wire [8:0] frame_len = {half_reg, 1'b0};
    wire [8:0] mcnt_next = (mcnt_reg == frame_len - 9'h001) ? 9'h000 : mcnt_reg + 9'h001;

    // Frame clock level due at the next falling bit clock edge
    always @* begin
        if (is_dsp) begin
            m_lr_next = (mcnt_next == 9'h000);
        end else if (fmt == `CASP_FMT_I2S) begin
            m_lr_next = (mcnt_next >= {1'b0, half_reg}) ^ pol;
        end else begin
            m_lr_next = (mcnt_next < {1'b0, half_reg}) ^ pol;
        end
    end

    // Divider and frame counter; both restart together so edges repeat
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= 8'h00;
            bclk_m_reg <= 1'b0;
            mcnt_reg <= `CASP_MCNT_IDLE;
            lr_m_reg <= 1'b0;
        end else if (!m_act) begin
            div_cnt_reg <= 8'h00;
            bclk_m_reg <= 1'b0;
            mcnt_reg <= `CASP_MCNT_IDLE;
            lr_m_reg <= 1'b0;
        end else if (tick) begin
            div_cnt_reg <= 8'h00;
            bclk_m_reg <= ~bclk_m_reg;
            // Frame clock moves only on falling bit clock edges
            if (bclk_m_reg) begin
                mcnt_reg <= mcnt_next;
                lr_m_reg <= m_lr_next;
            end
        end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
        end
    end

    // Clock pins: driven only in master role
    assign bclk_out = bclk_m_reg;
    assign lrclk_out = lr_m_reg;
    assign bclk_oe = role;
    assign lrclk_oe = role;

    // ----------------------------------------
    // Pin synchronisers and slave edge detect
    // ----------------------------------------
    wire bclk_s;
    wire lr_s;
    wire din_s;
    reg bclk_s_d_reg;
    casp_sync u_sync_bclk (.pclk(pclk), .presetn(presetn), .din(bclk_in), .dout(bclk_s));
    casp_sync u_sync_lr (.pclk(pclk), .presetn(presetn), .din(lrclk_in), .dout(lr_s));
    casp_sync u_sync_din (.pclk(pclk), .presetn(presetn), .din(playback_serial_in), .dout(din_s));

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bclk_s_d_reg <= 1'b0;
        end else begin
            bclk_s_d_reg <= bclk_s;
        end
    end

    // Slave: the far end owns both clocks
    wire s_act = run_reg & ~role;
    wire rise_ev = role ? m_rise : (s_act & bclk_s & ~bclk_s_d_reg);
    wire fall_ev = role ? m_fall : (s_act & ~bclk_s & bclk_s_d_reg);
    wire lr_cur = role ? m_lr_next : lr_s;
    assign lrclk_sel = role ? lr_m_reg : lr_s;

    // ----------------------------------------
    // Frame tracking on falling bit clock edges
    // ----------------------------------------
    reg lr_last_reg;
    reg [8:0] cnt_reg; // Number of the coming rising edge
    reg [8:0] meas_reg; // Length of the previous half frame
    reg ch_reg; // 1 while in the right half
    reg [23:0] sh_l_reg; // Capture shadows for the frame
    reg [23:0] sh_r_reg;
    wire lr_ch = (fmt == `CASP_FMT_I2S) ? (lr_cur ^ pol) : (~lr_cur ^ pol);
    wire edge_start = is_dsp ? (lr_cur & ~lr_last_reg) : (lr_cur != lr_last_reg);
    // DSP frames open on the pulse; other formats on the left half
    wire frame_start = edge_start & (is_dsp | ~lr_ch);
    wire [8:0] cnt_next = edge_start ? `CASP_FIRST_EDGE : cnt_reg + 9'h001;
    wire ch_next = edge_start ? lr_ch : ch_reg;
    wire [8:0] hl = role ? {1'b0, half_reg} : meas_reg;

    // Slot map: returns {hit, channel, bit index within the word}
    function [7:0] slot_map;
        input [8:0] p;
        input sl;
        input mx;
        input lch;
        reg [8:0] st;
        reg [8:0] off;
        reg [8:0] off2;
        reg [8:0] w;
        begin
            w = {3'h0, wl_len};
            slot_map = 8'h00;
            if (is_dsp) begin
                // Left then right back to back, slot 1 after both
                st = (pol ? `CASP_FIRST_EDGE : `CASP_SECOND_EDGE) + (sl ? {w[7:0], 1'b0} : 9'h000);
                off = p - st;
                off2 = off - w;
                if (p >= st && off < w) begin
                    slot_map = {2'b10, off[5:0]};
                end else if (p >= st && off < {w[7:0], 1'b0}) begin
                    slot_map = {2'b11, off2[5:0]};
                end
            end else begin
                case (fmt)
                    `CASP_FMT_RJ: st = hl - (mx ? {w[7:0], 1'b0} : w) + `CASP_FIRST_EDGE;
                    `CASP_FMT_LJ: st = `CASP_FIRST_EDGE;
                    default: st = `CASP_SECOND_EDGE;
                endcase
                st = st + (sl ? w : 9'h000);
                off = p - st;
                if (p >= st && off < w) begin
                    slot_map = {1'b1, lch, off[5:0]};
                end
            end
        end
    endfunction

    // Transmit side, evaluated for the coming rising edge
    wire [7:0] tmap = slot_map(cnt_next, cslot, cmx, ch_next);
    wire [5:0] tk = tmap[5:0];
    wire t_in = (tk < `CASP_SAMPLE_LEN);
    wire [4:0] tidx = `CASP_SAMPLE_MSB - tk[4:0];
    wire [23:0] src_l = frame_start ? cap_left_reg : sh_l_reg;
    wire [23:0] src_r = frame_start ? cap_right_reg : sh_r_reg;
    wire tbit = tmap[6] ? src_r[tidx] : src_l[tidx];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lr_last_reg <= 1'b0;
            cnt_reg <= 9'h000;
            meas_reg <= 9'h000;
            ch_reg <= 1'b0;
            sh_l_reg <= 24'h000000;
            sh_r_reg <= 24'h000000;
            capture_serial_out <= 1'b0;
            capture_oe <= 1'b0;
        end else if (!run_reg) begin
            capture_oe <= 1'b0;
            capture_serial_out <= 1'b0;
        end else if (fall_ev) begin
            lr_last_reg <= lr_cur;
            cnt_reg <= cnt_next;
            ch_reg <= ch_next;
            if (edge_start) begin
                meas_reg <= cnt_reg; // Feeds right justified placement
            end
            if (frame_start) begin
                sh_l_reg <= cap_left_reg;
                sh_r_reg <= cap_right_reg;
            end
            // Data changes on the falling edge, valid at the rising one
            capture_serial_out <= tmap[7] & t_in & tbit;
            // Low byte of 32-bit words left undriven
            capture_oe <= ~(tmap[7] & ~t_in) & (~cmx | tmap[7]);
        end
    end

    // ----------------------------------------
    // Receive side on rising bit clock edges
    // ----------------------------------------
    reg [23:0] acc_l_reg;
    reg [23:0] acc_r_reg;
    reg [23:0] rx_word;
    wire [7:0] rmap = slot_map(cnt_reg, pslot, pmx, ch_reg);
    wire [5:0] rk = rmap[5:0];
    wire [4:0] ridx = `CASP_SAMPLE_MSB - rk[4:0];
    wire r_hit = rise_ev & rmap[7];
    wire r_last = (rk == wl_len - 6'h01);

    // Fold the new bit into the word; first bit clears stale low bits
    always @* begin
        rx_word = (rk == 6'h00) ? 24'h000000 : (rmap[6] ? acc_r_reg : acc_l_reg);
        if (rk < `CASP_SAMPLE_LEN) begin
            rx_word[ridx] = din_s;
        end
    end

    // Completed words and flags; set beats a same-cycle clear
    always @* begin
        stat_set = 2'h0;
        if (r_hit && r_last) begin
            stat_set[rmap[6]] = 1'b1;
        end
        stat_next = stat_reg;
        if (apb_wr && addr_ok && aidx == `CASP_IDX_STAT) begin
            stat_next = stat_reg & ~pwdata[1:0];
        end
        stat_next = stat_next | stat_set;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_l_reg <= 24'h000000;
            acc_r_reg <= 24'h000000;
            play_left_reg <= 24'h000000;
            play_right_reg <= 24'h000000;
            stat_reg <= 2'h0;
        end else begin
            stat_reg <= stat_next;
            if (r_hit) begin
                if (rmap[6]) begin
                    acc_r_reg <= rx_word;
                end else begin
                    acc_l_reg <= rx_word;
                end
                // Mono PCM lands in the left word
                if (r_last && !rmap[6]) begin
                    play_left_reg <= rx_word;
                end
                if (r_last && rmap[6]) begin
                    play_right_reg <= rx_word;
                end
            end
        end
    end
endmodule // casp_serial_port

// *** casp_checker.sv ***
// Assertion checker for the audio serial port bus and pins
`timescale 1ns/10ps
module casp_checker (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic bclk_out,
    input logic bclk_oe,
    input logic lrclk_out,
    input logic lrclk_oe,
    input logic capture_serial_out,
    input logic capture_oe
);
    // ----------------------------------------
    // Shadow of format and run bits, falls since run
    // ----------------------------------------
    logic [1:0] fmt_q;
    logic run_q;
    logic bclk_d;
    logic [1:0] nf_q; // Saturates so stale frame state is skipped
    wire setup = psel && !penable;
    wire wr_hit = psel && penable && pwrite && pready;
    wire map_ok = paddr[11:6] == 6'h0 && paddr[1:0] == 2'h0 && paddr[5:2] >= 4'h7 && paddr[5:2] <= 4'hd;
    wire fall = bclk_d && !bclk_out;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt_q <= 2'h2;
            run_q <= 1'b0;
            bclk_d <= 1'b0;
            nf_q <= 2'h0;
        end else begin
            bclk_d <= bclk_out;
            if (wr_hit && paddr == 12'h01c)
                fmt_q <= pwdata[1:0];
            if (wr_hit && paddr == 12'h020)
                run_q <= pwdata[31];
            if (!run_q)
                nf_q <= 2'h0;
            else if (fall && nf_q != 2'h3)
                nf_q <= nf_q + 2'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    access_ready_a: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    bad_addr_a: assert property (setup && !map_ok |=> pslverr && prdata == 32'h0)
        else $error("unmapped address not refused");
    good_addr_a: assert property (setup && map_ok |=> !pslverr)
        else $error("mapped address refused");
    rdata_hold_a: assert property ($changed(prdata) |-> $past(setup))
        else $error("read data moved outside setup");
    same_role_a: assert property (bclk_oe == lrclk_oe)
        else $error("clock enables disagree");
    bclk_pace_a: assert property (run_q && $past(run_q) && bclk_oe && $changed(bclk_out) |=> !run_q || $stable(bclk_out))
        else $error("bit clock toggled twice in a row");
    lr_at_low_a: assert property (run_q && $past(run_q) && bclk_oe && $changed(lrclk_out) |-> !bclk_out)
        else $error("frame clock moved with bit clock high");
    cap_at_low_a: assert property (run_q && $past(run_q) && bclk_oe && $changed(capture_serial_out) |-> !bclk_out)
        else $error("capture data moved with bit clock high");
    dsp_pulse_a: assert property (bclk_oe && run_q && fmt_q == 2'h3 && nf_q == 2'h3 && fall && $past(lrclk_out)
        |-> ##[0:1] !lrclk_out)
        else $error("frame pulse wider than one bit");
    idle_quiet_a: assert property ((!run_q)[*3] |-> !capture_oe)
        else $error("capture driven while stopped");
endmodule // casp_checker
bind casp_serial_port casp_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bclk_out(bclk_out), .bclk_oe(bclk_oe), .lrclk_out(lrclk_out), .lrclk_oe(lrclk_oe),
    .capture_serial_out(capture_serial_out), .capture_oe(capture_oe));

// *** casp_partner.sv ***
// Far-side audio bus model: slave clock source, playback source, capture sink
`timescale 1ns/10ps
module casp_partner (
    input wire bclk,
    input wire lrclk,
    input wire cap_in,
    input wire gen_en,
    input wire dsp,
    input wire [5:0] lead,
    input wire left_lvl,
    input wire [23:0] pb_l,
    input wire [23:0] pb_r,
    output reg pb_out,
    output reg gen_bclk,
    output reg gen_lrclk,
    output reg [47:0] got
);
    integer rcnt = 1000; // Rises since frame start
    integer gcnt = 0;
    integer p;
    integer q;
    reg lr_r = 1'b0;
    wire [47:0] pbw = {pb_l, pb_r};
    // Bit slot of a rise: left then right, -1 outside the word
    function integer pos(input integer r, input lr);
        integer k;
        begin
            k = r - lead;
            if (k < 0 || k > (dsp ? 47 : 23))
                pos = -1;
            else if (!dsp && lr != left_lvl)
                pos = k + 24;
            else
                pos = k;
        end
    endfunction
    // Frame starts on any transition, or on the pulse rise in DSP
    function start(input lr);
        start = dsp ? (lr && !lr_r) : (lr != lr_r);
    endfunction
    initial begin
        pb_out = 1'b0;
        gen_bclk = 1'b0;
        gen_lrclk = 1'b0;
        got = 48'h0;
    end
    // Clocks stand still unless this side is master pulse falls 32 bits before next rise
    always #40 if (gen_en) gen_bclk = ~gen_bclk;
    always @(negedge gen_bclk) begin
        gcnt = gcnt + 1;
        if (gcnt == 32) begin
            gcnt = 0;
            gen_lrclk = ~gen_lrclk;
        end
    end
    // Capture bits taken on rises, MSB first
    always @(posedge bclk) begin
        rcnt = start(lrclk) ? 1 : rcnt + 1;
        lr_r = lrclk;
        p = pos(rcnt, lrclk);
        if (p >= 0)
            got[47 - p] = cap_in;
    end
    // Playback set just after the fall before its rise; off word it keeps toggling
    always @(negedge bclk) begin
        #1;
        q = pos(start(lrclk) ? 1 : rcnt + 1, lrclk);
        pb_out = (q >= 0) ? pbw[47 - q] : ~pb_out;
    end
endmodule // casp_partner

// *** tb_top.sv ***
// Self-checking testbench for the codec audio serial port
`timescale 1ns/10ps
module tb_top;
    // ----------------------------------------
    // Bus, pins and far-side controls
    // ----------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, bclk_out, bclk_oe, lrclk_out, lrclk_oe, cap_dat, cap_oe, pb_dat, gen_b, gen_lr;
    wire [47:0] got;
    logic gen_en = 1'b0, dsp = 1'b0, left_lvl = 1'b0;
    logic [5:0] lead = 6'h02;
    logic [23:0] pb_l = 24'h0, pb_r = 24'h0, cl, cr;
    logic [15:0] fc [5] = '{16'h48, 16'h49, 16'h4a, 16'h4b, 16'h5b};
    logic [5:0] fl [5] = '{6'd9, 6'd1, 6'd2, 6'd2, 6'd1};
    integer n_errors = 0, num_checks = 0, cyc = 0, oe_low = 0, i;
    // Whoever is master drives the shared clocks; capture line is pulled down
    wire bclk_w = bclk_oe ? bclk_out : gen_b;
    wire lrclk_w = lrclk_oe ? lrclk_out : gen_lr;
    wire cap_w = cap_oe ? cap_dat : 1'b0;
    casp_serial_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bclk_in(bclk_w),
        .bclk_out(bclk_out), .bclk_oe(bclk_oe), .lrclk_in(lrclk_w), .lrclk_out(lrclk_out), .lrclk_oe(lrclk_oe),
        .capture_serial_out(cap_dat), .capture_oe(cap_oe), .playback_serial_in(pb_dat));
    casp_partner u_far (.bclk(bclk_w), .lrclk(lrclk_w), .cap_in(cap_w), .gen_en(gen_en), .dsp(dsp), .lead(lead),
        .left_lvl(left_lvl), .pb_l(pb_l), .pb_r(pb_r), .pb_out(pb_dat), .gen_bclk(gen_b), .gen_lrclk(gen_lr),
        .got(got));
    initial forever #2 pclk = ~pclk;
    // Hang guard, well above the roughly 25k cycles the run needs
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            n_errors = n_errors + 1;
            wrap_up;
        end
    end
    always @(posedge bclk_w) if (!cap_oe) oe_low = oe_low + 1;
    task chk(input [47:0] g, input [47:0] x);
        num_checks = num_checks + 1;
        if (g !== x) begin
            n_errors = n_errors + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    // One transfer: setup, then access held until pready is seen high
    task apb(input w, input [11:0] a, input [31:0] d, output [31:0] r, output e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input [11:0] a, input [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task rd(input [11:0] a, input ex, input [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk({e, r}, {ex, x});
    endtask
    // Stop, reprogram, restart, then let four frames pass
    task go(input [15:0] c, input [31:0] k);
        wr(12'h020, {1'b0, k[30:0]});
        wr(12'h01c, {16'h0, c});
        wr(12'h020, k);
        repeat (4) @(posedge lrclk_w);
    endtask
    task t_regs;
        rd(12'h01c, 1'b0, 32'h0000000a);
        rd(12'h020, 1'b0, 32'h00200001);
        rd(12'h000, 1'b1, 32'h0);
        wr(12'h01c, 32'hffffffff);
        rd(12'h01c, 1'b0, 32'h00001e5f);
        wr(12'h024, 32'hff123456);
        rd(12'h024, 1'b0, 32'h00123456);
    endtask
    task t_formats;
        logic [31:0] r;
        logic e;
        for (i = 0; i < 5; i = i + 1) begin
            cl = 24'ha5c301 ^ {i[3:0], 20'h0};
            cr = 24'h3c5a81 ^ {20'h0, i[3:0]};
            pb_l <= 24'hc0ffe1 ^ {i[3:0], 20'h0};
            pb_r <= 24'h81e7d3 ^ {16'h0, i[3:0], 4'h0};
            lead <= fl[i];
            dsp <= fc[i][1:0] == 2'h3;
            left_lvl <= fc[i][1:0] != 2'h2;
            wr(12'h024, {8'h0, cl});
            wr(12'h028, {8'h0, cr});
            go(fc[i], 32'h80200004);
            chk(got, {cl, cr});
            rd(12'h02c, 1'b0, {8'h0, pb_l});
            rd(12'h030, 1'b0, {8'h0, pb_r});
        end
        apb(1'b0, 12'h034, 32'h0, r, e);
        chk(r & 32'h3, 32'h3);
    endtask
    task t_wl16;
        logic [31:0] r;
        logic e;
        lead <= 6'd2;
        dsp <= 1'b0;
        left_lvl <= 1'b0;
        go(16'h0042, 32'h80200004);
        chk(got, {cl[23:8], 8'h0, cr[23:8], 8'h0});
        apb(1'b0, 12'h02c, 32'h0, r, e);
        chk(r & 32'hffff00, {8'h0, pb_l[23:8], 8'h0});
    endtask
    task t_tdm;
        lead <= 6'd49;
        dsp <= 1'b1;
        pb_l <= 24'h5e0b17;
        go(16'h1e5b, 32'h80400004);
        oe_low = 0;
        repeat (2) @(posedge lrclk_w);
        chk(got, {cl, cr});
        rd(12'h02c, 1'b0, 32'h005e0b17);
        chk(oe_low != 0, 1'b1);
    endtask
    task t_slave;
        lead <= 6'd2;
        dsp <= 1'b1;
        left_lvl <= 1'b0;
        pb_r <= 24'h0badf1;
        gen_en <= 1'b1;
        go(16'h000b, 32'h80200004);
        chk(bclk_oe, 1'b0);
        chk(got, {cl, cr});
        rd(12'h030, 1'b0, 32'h000badf1);
        gen_en <= 1'b0;
    endtask
    task wrap_up;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_formats;
        t_wl16;
        t_tdm;
        t_slave;
        wrap_up;
    end
endmodule // tb_top
